// *** verilog/pin_select_map.vh ***
/*
 * Register map and constants of the port H / port J pin function select.
 * Assumes inclusion by bare name from the design file in this folder.
 */
`ifndef PIN_SELECT_MAP_VH
`define PIN_SELECT_MAP_VH

// Byte offsets of the two select registers on APB
`define PORT_H_FUNCTION_SELECT_OFS 12'h000
`define PORT_J_FUNCTION_SELECT_OFS 12'h004

// Power-on values
`define PORT_H_FUNCTION_SELECT_RST 32'h00000000
`define PORT_J_FUNCTION_SELECT_RST 32'h00000000

// Writable bits; bits above the last pin field read as zero
`define PORT_H_FUNCTION_SELECT_MASK 32'h3FFFFFFF
`define PORT_J_FUNCTION_SELECT_MASK 32'h03FFFFFF

// Pin counts and field layout
`define PORT_H_PINS 15
`define PORT_J_PINS 13
`define ALL_PINS 28
`define PORT_H_FIELD_BITS 30
`define PORT_J_FIELD_BITS 26

// Cycles the keeper ignores the synchroniser after the pad is let go
`define KEEPER_SETTLE 2'h3

// Mode field codes
`define MODE_GP_INPUT 2'h0
`define MODE_GP_OUTPUT 2'h1
`define MODE_RESERVED 2'h2
`define MODE_PERIPHERAL 2'h3

`endif

// *** verilog/pin_function_select.v ***
/*
 * Pin function select for port H (15 pins) and port J (13 pins): two APB
 * registers, per-pin mode decode, input synchronisers and pin keepers.
 * Assumes presetn is the power-on reset only; manual reset, standby and
 * sleep never reach this block, so the select registers survive them.
 * Port data bits come from the port data registers on the same clock.
 */
// Our own choices: register access over APB and the register offsets.
// Operation
// (RL1) The port H select register is 32 bits, read/write, zero at power-on.
// (RL2) The port J select register is 32 bits, read/write, zero at power-on.
// (RL3) Only power-on reset clears the select registers, nothing else does.
// (RL4) Bits 31 and 30 of port H and bits above the pin 12 field of J read 0.
// (RL5) Software writes zero into the reserved upper bits.
// (RL6) Port H holds a two-bit mode field for each of pins 0 to 14.
// (RL7) Port J holds a two-bit mode field for each of pins 0 to 12.
// (RL8) Mode 00 is general input, 01 general output, 11 peripheral function.
// (RL9) Software never programs mode 10 into any field.
// (RL10) Every pin of these ports has a keeper holding its last logic state.
// (RL11) On peripheral to input change the keeper holds the port data bit.
// (RL12) Pin n uses bit 2n+1 as high select and bit 2n as low select.
// (RL13) Output mode drives from port data; peripheral mode from peripheral.
`timescale 1ns/100ps
`default_nettype none
`include "pin_select_map.vh"

module pin_function_select (
	// Clock and power-on reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Port data register bits
	input wire [14:0] port_h_data,
	input wire [12:0] port_j_data,
	// Peripheral drive and enable per pin
	input wire [14:0] periph_h_out,
	input wire [14:0] periph_h_oe,
	input wire [12:0] periph_j_out,
	input wire [12:0] periph_j_oe,
	// Pads of port H
	input wire [14:0] pad_h_in,
	output wire [14:0] pad_h_out,
	output wire [14:0] pad_h_oe,
	output wire [14:0] pad_h_keep,
	// Pads of port J
	input wire [12:0] pad_j_in,
	output wire [12:0] pad_j_out,
	output wire [12:0] pad_j_oe,
	output wire [12:0] pad_j_keep,
	// Synchronised pin levels and peripheral inputs
	output wire [14:0] pin_h_level,
	output wire [12:0] pin_j_level,
	output wire [14:0] periph_h_in,
	output wire [12:0] periph_j_in
);

	reg [31:0] port_h_function_select_r;
	reg [31:0] port_j_function_select_r;
	reg [31:0] prdata_r;
	reg pready_r;
	reg pslverr_r;
	wire setup_phase;
	wire access_wr;
	wire hit_h;
	wire hit_j;

	// Flattened per-pin views: port H pins first, then port J
	wire [55:0] mode_all;
	wire [27:0] data_all;
	wire [27:0] pout_all;
	wire [27:0] poe_all;
	wire [27:0] pad_in_all;
	wire [27:0] level_all;
	wire [27:0] out_all;
	wire [27:0] oe_all;
	wire [27:0] keep_all;
	wire [27:0] periph_in_all;

	// APB decode
	assign setup_phase = psel & ~penable;
	assign access_wr = psel & penable & pwrite;
	assign hit_h = (paddr == `PORT_H_FUNCTION_SELECT_OFS);
	assign hit_j = (paddr == `PORT_J_FUNCTION_SELECT_OFS);

	// Select registers; cleared by power-on reset only
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_h_function_select_r <= `PORT_H_FUNCTION_SELECT_RST; // RL1 RL3
			port_j_function_select_r <= `PORT_J_FUNCTION_SELECT_RST; // RL2 RL3
		end
		else if (access_wr)
		begin
			// Reserved bits are forced low whatever is written
			if (hit_h)
				port_h_function_select_r <=
					pwdata & `PORT_H_FUNCTION_SELECT_MASK; // RL1 RL4
			if (hit_j)
				port_j_function_select_r <=
					pwdata & `PORT_J_FUNCTION_SELECT_MASK; // RL2 RL4
		end
	end

	// Read data and error captured in the setup phase, zero wait states
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= 1'b1;
			if (setup_phase)
			begin
				pslverr_r <= ~(hit_h | hit_j);
				if (pwrite)
					prdata_r <= 32'h00000000;
				else if (hit_h)
					prdata_r <= port_h_function_select_r; // RL1
				else if (hit_j)
					prdata_r <= port_j_function_select_r; // RL2
				else
					prdata_r <= 32'h00000000;
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// Mode fields in pin order, two bits per pin
	assign mode_all = {
		port_j_function_select_r[`PORT_J_FIELD_BITS-1:0], // RL7
		port_h_function_select_r[`PORT_H_FIELD_BITS-1:0] // RL6
	};
	assign data_all = {port_j_data, port_h_data};
	assign pout_all = {periph_j_out, periph_h_out};
	assign poe_all = {periph_j_oe, periph_h_oe};
	assign pad_in_all = {pad_j_in, pad_h_in};

	// Per-pin decode, synchroniser and keeper
	genvar n;
	generate
		for (n = 0; n < `ALL_PINS; n = n + 1)
		begin : g_pin
			wire [1:0] mode;
			wire agree;
			reg [1:0] mode_prev_r;
			reg [1:0] quiet_r;
			reg sync1_r;
			reg sync2_r;
			reg sync3_r;
			reg level_r;
			reg out_r;
			reg oe_r;
			reg keep_r;
			reg periph_in_r;
			assign mode = mode_all[2*n+1:2*n]; // RL12
			assign agree = (sync2_r == sync3_r);

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					sync1_r <= 1'b0;
					sync2_r <= 1'b0;
					sync3_r <= 1'b0;
					level_r <= 1'b0;
					out_r <= 1'b0;
					oe_r <= 1'b0;
					keep_r <= 1'b0;
					quiet_r <= 2'h0;
					periph_in_r <= 1'b0;
					mode_prev_r <= `MODE_GP_INPUT;
				end
				else
				begin
					// Three-stage pad synchroniser, level taken on agreement
					sync1_r <= pad_in_all[n];
					sync2_r <= sync1_r;
					sync3_r <= sync2_r;
					if (agree)
						level_r <= sync2_r;
					mode_prev_r <= mode;

					// Drive and enable from the selected source
					case (mode)
						`MODE_GP_OUTPUT:
						begin
							out_r <= data_all[n]; // RL8 RL13
							oe_r <= 1'b1; // RL13
						end
						`MODE_PERIPHERAL:
						begin
							out_r <= pout_all[n]; // RL8 RL13
							oe_r <= poe_all[n]; // RL13
						end
						default:
						begin
							// Input, and the unsupported code, drive nothing
							out_r <= 1'b0; // RL8
							oe_r <= 1'b0;
						end
					endcase

					// Peripheral sees the pin only in peripheral mode
					if (mode == `MODE_PERIPHERAL)
						periph_in_r <= level_r;
					else
						periph_in_r <= 1'b0;

					// Keeper: track driven value, else the settled level;
					// the synchroniser still holds the old drive for a few
					// cycles after release, so it is ignored until flushed
					if (mode_prev_r == `MODE_PERIPHERAL &&
						mode == `MODE_GP_INPUT)
					begin
						keep_r <= data_all[n]; // RL11
						quiet_r <= `KEEPER_SETTLE;
					end
					else if (oe_r)
					begin
						keep_r <= out_r; // RL10
						quiet_r <= `KEEPER_SETTLE;
					end
					else if (quiet_r != 2'h0)
						quiet_r <= quiet_r - 2'h1;
					else if (agree)
						keep_r <= sync2_r; // RL10
				end
			end

			// Flattened per-pin results for the port outputs
			assign level_all[n] = level_r;
			assign out_all[n] = out_r;
			assign oe_all[n] = oe_r;
			assign keep_all[n] = keep_r;
			assign periph_in_all[n] = periph_in_r;
		end
	endgenerate

	// Pad and level outputs, all from flops
	assign pad_h_out = out_all[14:0];
	assign pad_h_oe = oe_all[14:0];
	assign pad_h_keep = keep_all[14:0];
	assign pad_j_out = out_all[27:15];
	assign pad_j_oe = oe_all[27:15];
	assign pad_j_keep = keep_all[27:15];
	assign pin_h_level = level_all[14:0];
	assign pin_j_level = level_all[27:15];
	assign periph_h_in = periph_in_all[14:0];
	assign periph_j_in = periph_in_all[27:15];

endmodule

`default_nettype wire

// *** dv/pin_select_monitor.sv ***
/* Checker for the pin select block ports.
   Assumes binding onto pin_function_select, one clock. */
`timescale 1ns/100ps
`default_nettype none
module pin_select_monitor (
	// Clock, reset and APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic [14:0] port_h_data,
	input wire logic [14:0] periph_h_oe,
	input wire logic [14:0] pad_h_out,
	input wire logic [14:0] pad_h_oe,
	input wire logic [12:0] pad_j_oe,
	input wire logic [14:0] periph_h_in
);
	// Setup and write strobes per register
	wire logic su = psel && !penable;
	wire logic wh = psel && penable && pwrite && paddr == 12'h000;
	wire logic wj = psel && penable && pwrite && paddr == 12'h004;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_RDY: assert property ($past(presetn) |-> pready)
		else $error("pready low");
	AST_MSKH: assert property (su && paddr == 12'h000 |=> prdata[31:30] == 2'h0)
		else $error("port h reserved bits set");
	AST_MSKJ: assert property (su && paddr == 12'h004 |=> prdata[31:26] == 6'h00)
		else $error("port j reserved bits set");
	AST_ERR: assert property (su && paddr != 12'h000 && paddr != 12'h004 |=> pslverr)
		else $error("unmapped access accepted");
	AST_OUT: assert property (wh && pwdata[1:0] == 2'h1 |-> ##2 pad_h_oe[0] && pad_h_out[0] == $past(port_h_data[0]))
		else $error("output mode wrong");
	AST_PER: assert property (wh && pwdata[1:0] == 2'h3 |-> ##2 pad_h_oe[0] == $past(periph_h_oe[0]))
		else $error("peripheral enable wrong");
	AST_IN: assert property (wh && !pwdata[0] |-> ##2 !pad_h_oe[0] && !periph_h_in[0])
		else $error("input mode drives");
	AST_OUTJ: assert property (wj && pwdata[1:0] == 2'h1 |-> ##2 pad_j_oe[0])
		else $error("port j output mode wrong");
	cover property (wh && pwdata[1:0] == 2'h3);
	cover property (wj && pwdata[1:0] == 2'h1);
	cover property (su ##1 pslverr);
endmodule
bind pin_function_select pin_select_monitor i_mon (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .port_h_data(port_h_data), .periph_h_oe(periph_h_oe),
	.pad_h_out(pad_h_out), .pad_h_oe(pad_h_oe), .pad_j_oe(pad_j_oe),
	.periph_h_in(periph_h_in));
`default_nettype wire

// *** dv/pin_partner.sv ***
/* Pad model: block drive wins, else an outside driver, else the keeper.
   Assumes the bench chooses which pads are driven from outside. */
`timescale 1ns/100ps
`default_nettype none
module pin_partner #(parameter W = 15) (
	// Block side and outside driver
	input wire logic [W-1:0] pad_out,
	input wire logic [W-1:0] pad_oe,
	input wire logic [W-1:0] pad_keep,
	input wire logic [W-1:0] ext_drv,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] pad_in
);
	// Undriven pads fall back to the keeper level
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
		| (~pad_oe & ~ext_drv & pad_keep);
endmodule
`default_nettype wire

// *** dv/port_h_j_pin_function_select_tb.sv ***
/* Bench for the pin select block with random modes and pad levels.
   Assumes pin_partner and the bound checker are compiled before. */
`timescale 1ns/100ps
`default_nettype none
module port_h_j_pin_function_select_tb;
	// Bench state
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, d, d2;
	logic [14:0] hd = 0, ho = 0, he = 0, hx = 0, hv = 0;
	logic [12:0] jd = 0, jo = 0, je = 0;
	logic [44:0] e;
	logic [15:0] sd = 16'hAC24;
	wire [31:0] prdata;
	wire pready, pslverr;
	wire [14:0] hpo, hoe, hk, hin, hl, hpi;
	wire [12:0] jpo, joe, jk, jin, jl, jpi;
	int n_fail = 0, checks = 0, i;
	always #5 pclk = ~pclk;
	pin_function_select i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_h_data(hd), .port_j_data(jd), .periph_h_out(ho),
		.periph_h_oe(he), .periph_j_out(jo), .periph_j_oe(je),
		.pad_h_in(hin), .pad_h_out(hpo), .pad_h_oe(hoe), .pad_h_keep(hk),
		.pad_j_in(jin), .pad_j_out(jpo), .pad_j_oe(joe), .pad_j_keep(jk),
		.pin_h_level(hl), .pin_j_level(jl), .periph_h_in(hpi),
		.periph_j_in(jpi));
	pin_partner #(.W(15)) i_ph (.pad_out(hpo), .pad_oe(hoe), .pad_keep(hk),
		.ext_drv(hx), .ext_val(hv), .pad_in(hin));
	pin_partner #(.W(13)) i_pj (.pad_out(jpo), .pad_oe(joe), .pad_keep(jk),
		.ext_drv(13'h0000), .ext_val(13'h0000), .pad_in(jin));
	// Random source
	function logic [31:0] rn();
		sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
		rn[31:16] = sd;
		sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
		rn[15:0] = sd;
	endfunction
	// Legal write value: reserved bits zero, mode 10 turned into 11
	function logic [31:0] fx(logic [31:0] v, m);
		fx = (v & m) | (((v & m) >> 1) & 32'h15555555);
	endfunction
	// Expected {periph_in, oe, level} per pin
	function logic [44:0] pe(logic [31:0] m, logic [14:0] dt, ot, oe, v);
		for (int n = 0; n < 15; n++)
		begin
			pe[15+n] = m[2*n+:2] == 2'h1 || (m[2*n+:2] == 2'h3 && oe[n]);
			pe[n] = !pe[15+n] ? v[n] : m[2*n+1] ? ot[n] : dt[n];
			pe[30+n] = m[2*n+:2] == 2'h3 && pe[n];
		end
	endfunction
	task chk(string s, logic [44:0] x, g);
		checks++;
		if (x !== g)
		begin
			n_fail++;
			$display("wrong value %s exp %h got %h", s, x, g);
		end
	endtask
	// One APB transfer, held until pready
	task xf(logic w, logic [11:0] a, logic [31:0] v);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task results();
		if (n_fail == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		results();
	end
	// Main sequence
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		xf(0, 12'h000, 32'h0);
		chk("h reset", 0, rd);
		xf(0, 12'h004, 32'h0);
		chk("j reset", 0, rd);
		xf(1, 12'h000, 32'hFFFFFFFF);
		xf(1, 12'h004, 32'hFFFFFFFF);
		xf(1, 12'h00C, 32'h0);
		chk("unmapped", 1, er);
		xf(0, 12'h000, 32'h0);
		chk("h mask", 32'h3FFFFFFF, rd);
		xf(0, 12'h004, 32'h0);
		chk("j mask", 32'h03FFFFFF, rd);
		for (i = 0; i < 40; i++)
		begin
			{hd, ho, he, hv, jd, jo, je} <= {rn(), rn(), rn(), 3'h0};
			d = fx(rn(), 32'h3FFFFFFF);
			d2 = fx(rn(), 32'h03FFFFFF);
			@(posedge pclk);
			e = pe(d, hd, ho, he, hv);
			hx <= ~e[29:15];
			xf(1, 12'h000, d);
			xf(1, 12'h004, d2);
			xf(0, 12'h000, 32'h0);
			chk("h read", d, rd);
			xf(0, 12'h004, 32'h0);
			chk("j read", d2, rd);
			repeat (6) @(posedge pclk);
			chk("h pins", e, {hpi, hoe, hl});
			chk("h keep", e[14:0], hk);
			e = pe(d2, {2'h0, jd}, {2'h0, jo}, {2'h0, je}, 15'h0000);
			chk("j oe", e[27:15], joe);
			chk("j level", e[12:0], jl & e[27:15]);
			chk("j periph", e[42:30], jpi & e[27:15]);
			chk("j keep", e[12:0], jk & e[27:15]);
		end
		// Peripheral drive handed back to input: keeper takes the data bit
		{hx, hd, ho, he} <= {15'h0000, 15'h0000, 15'h0001, 15'h0001};
		xf(1, 12'h000, 32'h00000003);
		repeat (6) @(posedge pclk);
		chk("h drive", 3'h7, {hpo[0], hoe[0], hk[0]});
		xf(1, 12'h000, 32'h00000000);
		repeat (8) @(posedge pclk);
		chk("h keep hold", 2'h0, {hk[0], hl[0]});
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		xf(0, 12'h000, 32'h0);
		chk("h reset again", 0, rd);
		results();
	end
endmodule
`default_nettype wire
